// [hw/seq_pkg.sv]
// Purpose: Shared constants and carrier types for the two-wire transfer sequencer host.
// Assumes: 100 MHz clock, 8-bit parallel port to the bus controller device.
// Notes: Control words are the values the device expects on its control port.
package seq_pkg;

  // Control words written with the register-select line high.
  localparam logic [7:0] CTL_SEL_OWN = 8'h00;
  localparam logic [7:0] CTL_SEL_CLOCK = 8'h20;
  localparam logic [7:0] CTL_SEL_STATUS = 8'h40;
  localparam logic [7:0] CTL_START = 8'h4D;
  localparam logic [7:0] CTL_STOP = 8'hC3;
  localparam logic [7:0] CTL_NO_ACK = 8'h48;

  // Status bit position of the active-low bus busy flag.
  localparam int BUSY_BIT = 0;

  // Port access timing: strobe width in ns, rounded up to clock cycles.
  localparam int STROBE_NS = 40;
  localparam int CLK_NS = 10;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);

  // Table depth and index width.
  localparam int TABLE_DEPTH = 16;
  localparam int IDX_W = 4;

  // APB register byte addresses.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SETUP = 8'h08;
  localparam logic [7:0] REG_TABLE = 8'h0C;

  // Reset values.
  localparam logic [7:0] OWN_ADDR_RESET = 8'h55;
  localparam logic [7:0] CLOCK_RESET = 8'h1C;

  // One access on the device's parallel port.
  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] data;
  } port_req_t;

  // Device-side pins driven by the host.
  typedef struct packed {
    logic cs_b;
    logic rd_b;
    logic wr_b;
    logic sel;
    logic [7:0] dout;
    logic doe;
  } dev_pins_t;

endpackage : seq_pkg

// [hw/port_access.sv]
// Purpose: Performs one read or write on the device's 8-bit parallel port.
// Assumes: Device answers within a fixed strobe width; data pins are eight signals.
// Notes: Read data is captured at the end of the strobe.
`timescale 1ns/1ps
module port_access (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Request side.
  input wire logic req_i,
  input wire seq_pkg::port_req_t cmd_i,
  output logic done_o,
  output logic [7:0] rdata_o,
  // Device pins.
  input wire logic [7:0] din_i,
  output seq_pkg::dev_pins_t pins_o
);

  logic [3:0] cnt;
  logic busy;
  logic [7:0] din_s1;
  logic [7:0] din_s2;
  logic [7:0] din_s3;
  wire strobe_end = busy && (cnt == seq_pkg::STROBE_CYC);

  // Data pins pass three flops; the late pair must agree before capture.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      din_s1 <= 8'h00;
      din_s2 <= 8'h00;
      din_s3 <= 8'h00;
    end else begin
      din_s1 <= din_i;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
    end
  end

  // Strobe sequencing; the strobe is held long enough for the sync chain.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
      pins_o <= '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1, sel: 1'b0, dout: 8'h00, doe: 1'b0};
    end else begin
      done_o <= 1'b0;
      if (!busy && req_i) begin
        busy <= 1'b1;
        cnt <= 4'h0;
        pins_o.cs_b <= 1'b0;
        pins_o.sel <= cmd_i.sel;
        pins_o.rd_b <= cmd_i.wr;
        pins_o.wr_b <= ~cmd_i.wr;
        pins_o.dout <= cmd_i.data;
        pins_o.doe <= cmd_i.wr;
      end else if (strobe_end && (cmd_i.wr || din_s2 == din_s3)) begin
        busy <= 1'b0;
        done_o <= 1'b1;
        rdata_o <= din_s3;
        pins_o.cs_b <= 1'b1;
        pins_o.rd_b <= 1'b1;
        pins_o.wr_b <= 1'b1;
        pins_o.doe <= 1'b0;
      end else if (busy && !strobe_end) begin
        cnt <= cnt + 4'h1;
      end
    end
  end

endmodule : port_access

// [hw/transfer_host.sv]
// Purpose: Host that drives the byte-level two-wire controller through whole transfers.
// Assumes: Device interrupt is active low; the table_pointer address is even so select is bit 0.
// Notes: Software loads the table and count over APB, then starts; done reads back.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module transfer_host (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_b_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Device port.
  input wire logic [7:0] dev_din_i,
  input wire logic dev_int_b_i,
  output logic dev_cs_b_o,
  output logic dev_rd_b_o,
  output logic dev_wr_b_o,
  output logic dev_sel_o,
  output logic [7:0] dev_dout_o,
  output logic dev_doe_o
);

  typedef enum {
    ST_INIT_OWN_SEL,
    ST_INIT_OWN,
    ST_INIT_CLK_SEL,
    ST_INIT_CLK,
    ST_IDLE,
    ST_STAT_SEL,
    ST_POLL,
    ST_ADDR,
    ST_LAUNCH,
    ST_WAIT_INT,
    ST_TX_DATA,
    ST_RX_NOACK,
    ST_RX_READ,
    ST_STOP
  } state_t;

  state_t state;
  state_t next_state;
  logic [7:0] table_mem [seq_pkg::TABLE_DEPTH];
  logic [7:0] requested_byte_count;
  logic [7:0] transferred_byte_counter;
  logic [seq_pkg::IDX_W-1:0] table_pointer;
  logic [7:0] target_addr;
  logic [7:0] own_addr;
  logic [7:0] clock_setting;
  logic direction_tx;
  logic transfer_done;
  logic start_req;
  logic issued;
  logic [2:0] int_sync;
  logic int_seen;
  logic prev_high;
  logic [seq_pkg::IDX_W-1:0] wr_idx;
  logic acc_done;
  logic [7:0] acc_rdata;
  seq_pkg::port_req_t cmd;
  seq_pkg::dev_pins_t pins;

  // APB decode; the slave always answers in the first access cycle.
  wire apb_setup = psel_i && !penable_i;
  wire apb_wr = psel_i && penable_i && pwrite_i;
  wire hit_ctrl = paddr_i == seq_pkg::REG_CTRL;
  wire hit_stat = paddr_i == seq_pkg::REG_STATUS;
  wire hit_setup = paddr_i == seq_pkg::REG_SETUP;
  wire hit_table = paddr_i == seq_pkg::REG_TABLE;
  wire hit_any = hit_ctrl || hit_stat || hit_setup || hit_table;
  wire [31:0] rd_mux = hit_stat ? {16'h0000, transferred_byte_counter, 6'h00,
                                   direction_tx, transfer_done} :
                       hit_ctrl ? {24'h000000, target_addr} :
                       hit_setup ? {16'h0000, clock_setting, own_addr} :
                       hit_table ? {24'h000000, table_mem[wr_idx]} : 32'h0000_0000;

  // Software writes. The control word lands only while the sequencer rests, so a
  // write issued in mid-transfer can neither retarget nor restart it.
  wire idle_done = transfer_done && (state == ST_IDLE);
  wire ctrl_load = apb_wr && hit_ctrl && idle_done;
  wire start_load = ctrl_load && pwdata_i[8];
  wire setup_load = apb_wr && hit_setup;
  wire table_load = apb_wr && hit_table;

  // Interrupt pin passes three flops; a level counts once the late pair agree.
  // Only the first agreed low after an agreed high is an event, so a long low
  // pulse can never be taken for two bytes.
  wire int_low = !int_sync[1] && !int_sync[2];
  wire int_high = int_sync[1] && int_sync[2];
  wire int_fall = int_low && prev_high;

  // Counter tests; receive counts ahead by one for the discarded dummy read.
  wire all_done = transferred_byte_counter == requested_byte_count;
  wire last_rx = (transferred_byte_counter + 8'd2) == requested_byte_count;
  wire rx_final = (transferred_byte_counter + 8'd1) == requested_byte_count;

  // Port handshake: one request per access state, re-armed by each completion so
  // that a repeated status poll issues a fresh read instead of stalling.
  wire acc_state = (state != ST_IDLE) && (state != ST_WAIT_INT);
  wire acc_req = acc_state && !issued;

  // Completion events that move the counter, the pointer and the done flag.
  wire begin_seq = (state == ST_IDLE) && (next_state == ST_STAT_SEL);
  wire addr_sent = (state == ST_ADDR) && acc_done;
  wire tx_sent = (state == ST_TX_DATA) && acc_done;
  wire rx_taken = (state == ST_RX_READ) && acc_done;
  wire rx_store = rx_taken && (transferred_byte_counter != 8'h00);
  wire stop_sent = (state == ST_STOP) && acc_done;

  // Command chosen per state; select high addresses control on write, status on read.
  always_comb begin
    cmd = '{sel: 1'b1, wr: 1'b1, data: 8'h00};
    case (state)
      ST_INIT_OWN_SEL: cmd.data = seq_pkg::CTL_SEL_OWN;
      ST_INIT_OWN: cmd = '{sel: 1'b0, wr: 1'b1, data: own_addr};
      ST_INIT_CLK_SEL: cmd.data = seq_pkg::CTL_SEL_CLOCK;
      ST_INIT_CLK: cmd = '{sel: 1'b0, wr: 1'b1, data: clock_setting};
      ST_STAT_SEL: cmd.data = seq_pkg::CTL_SEL_STATUS;
      ST_POLL: cmd = '{sel: 1'b1, wr: 1'b0, data: 8'h00};
      ST_ADDR: cmd = '{sel: 1'b0, wr: 1'b1, data: target_addr};
      ST_LAUNCH: cmd.data = seq_pkg::CTL_START;
      ST_TX_DATA: cmd = '{sel: 1'b0, wr: 1'b1, data: table_mem[table_pointer]};
      ST_RX_NOACK: cmd.data = seq_pkg::CTL_NO_ACK;
      ST_RX_READ: cmd = '{sel: 1'b0, wr: 1'b0, data: 8'h00};
      ST_STOP: cmd.data = seq_pkg::CTL_STOP;
      default: cmd = '{sel: 1'b1, wr: 1'b1, data: 8'h00};
    endcase
  end

  // Next state; each access state leaves once its port access completes, ST_POLL only once the read shows the bus free.
  always_comb begin
    next_state = state;
    case (state)
      // Initialisation after reset: own address first, then the clock byte.
      ST_INIT_OWN_SEL: if (acc_done) next_state = ST_INIT_OWN;
      ST_INIT_OWN: if (acc_done) next_state = ST_INIT_CLK_SEL;
      ST_INIT_CLK_SEL: if (acc_done) next_state = ST_INIT_CLK;
      ST_INIT_CLK: if (acc_done) next_state = ST_IDLE;
      // Sequence: status select, poll until free, address byte, launch.
      ST_IDLE: if (start_req && transfer_done) next_state = ST_STAT_SEL;
      ST_STAT_SEL: if (acc_done) next_state = ST_POLL;
      ST_POLL: if (acc_done && acc_rdata[seq_pkg::BUSY_BIT]) next_state = ST_ADDR;
      ST_ADDR: if (acc_done) next_state = ST_LAUNCH;
      ST_LAUNCH: if (acc_done) next_state = ST_WAIT_INT;
      // Handler entry: the direction flag picks the transmit or the receive path.
      ST_WAIT_INT: begin
        if (int_seen) begin
          if (direction_tx) begin
            next_state = all_done ? ST_STOP : ST_TX_DATA;
          end else begin
            next_state = last_rx ? ST_RX_NOACK : ST_RX_READ;
          end
        end
      end
      // Handler bodies: transmit returns to waiting, no-ack goes on to the read, the read waits again unless the count ends the sequence.
      ST_TX_DATA: if (acc_done) next_state = ST_WAIT_INT;
      ST_RX_NOACK: if (acc_done) next_state = ST_RX_READ;
      ST_RX_READ: begin
        if (acc_done) begin
          next_state = rx_final ? ST_STOP : ST_WAIT_INT;
        end
      end
      ST_STOP: if (acc_done) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Port access engine; one request per access state.
  port_access u_port (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .req_i(acc_req),
    .cmd_i(cmd),
    .done_o(acc_done),
    .rdata_o(acc_rdata),
    .din_i(dev_din_i),
    .pins_o(pins)
  );

  // State, handshake and interrupt event capture.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_INIT_OWN_SEL;
      issued <= 1'b0;
      int_sync <= 3'b111;
      int_seen <= 1'b0;
    end else begin
      state <= next_state;
      int_sync <= {int_sync[1:0], dev_int_b_i};
      issued <= acc_done ? 1'b0 : (issued || acc_req);
      // An event latches until the handler takes it; a new edge in that cycle wins.
      if (int_fall) begin
        int_seen <= 1'b1;
      end else if (state == ST_WAIT_INT && int_seen) begin
        int_seen <= 1'b0;
      end
    end
  end

  // Remember the interrupt pin was high so only the falling edge counts.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_high <= 1'b1;
    end else if (int_high) begin
      prev_high <= 1'b1;
    end else if (int_low) begin
      prev_high <= 1'b0;
    end
  end

  // Counter and pointer; the pointer skips the dummy read so stored bytes start at
  // entry zero. Sixteen entries: longer counts wrap and reuse the table.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      transferred_byte_counter <= 8'h00;
      table_pointer <= '0;
    end else if (begin_seq) begin
      transferred_byte_counter <= 8'h00;
      table_pointer <= '0;
    end else if (tx_sent) begin
      table_pointer <= table_pointer + 1'b1;
      transferred_byte_counter <= transferred_byte_counter + 8'd1;
    end else if (rx_taken) begin
      transferred_byte_counter <= transferred_byte_counter + 8'd1;
      if (rx_store) begin
        table_pointer <= table_pointer + 1'b1;
      end
    end
  end

  // Done flag and start request; done stays high from reset until an address is sent.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      transfer_done <= 1'b1;
      start_req <= 1'b0;
    end else begin
      if (start_load) begin
        start_req <= 1'b1;
      end else if (state == ST_STAT_SEL) begin
        start_req <= 1'b0;
      end
      if (addr_sent) begin
        transfer_done <= 1'b0;
      end else if (stop_sent) begin
        transfer_done <= 1'b1;
      end
    end
  end

  // Table storage: APB writes go to the index, received bytes to the pointer.
  generate
    for (genvar i = 0; i < seq_pkg::TABLE_DEPTH; i++) begin : g_table
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          table_mem[i] <= 8'h00;
        end else if (rx_store && table_pointer == i) begin
          table_mem[i] <= acc_rdata;
        end else if (table_load && wr_idx == i) begin
          table_mem[i] <= pwdata_i[7:0];
        end
      end
    end
  endgenerate

  // APB response flops. Read data and the error flag are taken in the setup cycle so
  // they stand in the access cycle, when the master samples them with ready.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= apb_setup;
      pslverr_o <= apb_setup && !hit_any;
      if (apb_setup && !pwrite_i) begin
        prdata_o <= rd_mux;
      end
    end
  end

  // Software configuration registers.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      target_addr <= 8'h00;
      requested_byte_count <= 8'h00;
      direction_tx <= 1'b1;
      own_addr <= seq_pkg::OWN_ADDR_RESET;
      clock_setting <= seq_pkg::CLOCK_RESET;
      wr_idx <= '0;
    end else begin
      if (ctrl_load) begin
        target_addr <= pwdata_i[7:0];
        direction_tx <= pwdata_i[9];
        // Receive adds one for the dummy first read.
        requested_byte_count <= pwdata_i[9] ? pwdata_i[23:16] : pwdata_i[23:16] + 8'd1;
      end
      if (setup_load) begin
        own_addr <= pwdata_i[7:0];
        clock_setting <= pwdata_i[15:8];
        wr_idx <= pwdata_i[16 +: seq_pkg::IDX_W];
      end
      if (table_load) begin
        wr_idx <= wr_idx + 1'b1;
      end
    end
  end

  // Pins come straight from the access engine's flops.
  assign dev_cs_b_o = pins.cs_b;
  assign dev_rd_b_o = pins.rd_b;
  assign dev_wr_b_o = pins.wr_b;
  assign dev_sel_o = pins.sel;
  assign dev_dout_o = pins.dout;
  assign dev_doe_o = pins.doe;

endmodule : transfer_host

// [tb/transfer_host_props.sv]
// Purpose: Port checker for the transfer host.
// Assumes: Five-cycle device strobes and zero-wait APB answers.
// Notes: Bound onto every transfer_host instance.
`timescale 1ns/1ps
module transfer_host_props (
  // Clock, reset and APB.
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Device port.
  input wire logic dev_cs_b_o,
  input wire logic dev_rd_b_o,
  input wire logic dev_wr_b_o,
  input wire logic dev_sel_o,
  input wire logic [7:0] dev_dout_o,
  input wire logic dev_doe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // Strobes are timed so a slow device still latches a whole access.
  property p_wr_width; $fell(dev_wr_b_o) |-> !dev_wr_b_o [*5] ##1 dev_wr_b_o; endproperty
  property p_rd_width; $fell(dev_rd_b_o) |-> !dev_rd_b_o [*5] ##1 dev_rd_b_o; endproperty
  property p_cs_cover; (!dev_wr_b_o || !dev_rd_b_o) |-> !dev_cs_b_o; endproperty
  property p_doe_wr; !dev_wr_b_o |-> dev_doe_o; endproperty
  property p_doe_rd; !dev_rd_b_o |-> !dev_doe_o; endproperty
  property p_hold; !dev_wr_b_o && $past(!dev_wr_b_o) |-> $stable(dev_dout_o) && $stable(dev_sel_o);
  endproperty
  property p_gap; $rose(dev_cs_b_o) |=> dev_cs_b_o; endproperty
  property p_answer; psel_i && !penable_i ##1 psel_i && penable_i |-> pready_o; endproperty
  property p_once; pready_o |=> !pready_o; endproperty
  property p_err; pready_o |-> pslverr_o == !(paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0C});
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("write strobe width wrong");
  a_rd_width: assert property (p_rd_width) else $error("read strobe width wrong");
  a_cs_cover: assert property (p_cs_cover) else $error("strobe without select");
  a_doe_wr: assert property (p_doe_wr) else $error("data not driven on write");
  a_doe_rd: assert property (p_doe_rd) else $error("data driven on read");
  a_hold: assert property (p_hold) else $error("write data moved in strobe");
  a_gap: assert property (p_gap) else $error("accesses not separated");
  a_answer: assert property (p_answer) else $error("no ready in access cycle");
  a_once: assert property (p_once) else $error("ready held too long");
  a_err: assert property (p_err) else $error("error flag wrong");
  // Main scenarios seen on the control port.
  c_start: cover property ($fell(dev_wr_b_o) && dev_sel_o && dev_dout_o == seq_pkg::CTL_START);
  c_stop: cover property ($fell(dev_wr_b_o) && dev_sel_o && dev_dout_o == seq_pkg::CTL_STOP);
  c_nack: cover property ($fell(dev_wr_b_o) && dev_sel_o && dev_dout_o == seq_pkg::CTL_NO_ACK);
endmodule : transfer_host_props
bind transfer_host transfer_host_props props (.clock_i, .rst_b_i, .psel_i, .penable_i,
  .paddr_i, .pready_o, .pslverr_o, .dev_cs_b_o, .dev_rd_b_o, .dev_wr_b_o, .dev_sel_o,
  .dev_dout_o, .dev_doe_o);

// [tb/ctl_device_model.sv]
// Purpose: Behavioural bus controller device seen by the host.
// Assumes: Each bus byte takes 40 cycles; interrupt is low 4 cycles.
// Notes: Reports every byte moved with the acknowledge bit then in force.
`timescale 1ns/1ps
module ctl_device_model (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Host port.
  input wire seq_pkg::dev_pins_t pins_i,
  output logic [7:0] din_o,
  output logic int_b_o,
  // Bench hooks.
  input wire logic [7:0] rx_seed_i,
  output logic ev_o,
  output logic [8:0] ev_data_o,
  output logic init_ok_o,
  output logic [7:0] own_o,
  output logic [7:0] clk_o
);
  logic [7:0] ctl, dreg, pat, k;
  logic busy, rx, aph, seen, wr_q, rd_q;
  logic [5:0] tmr;
  logic [2:0] ints;
  // Access starts and pointer decode; an idle bus shows a toggling pattern, not old data.
  wire wr_go = !pins_i.cs_b && !pins_i.wr_b && wr_q;
  wire rd_go = !pins_i.cs_b && !pins_i.rd_b && rd_q;
  wire dptr = ctl[6] && !ctl[4];
  wire [7:0] rval = pins_i.sel ? {7'h00, !busy} : (dptr ? dreg : (ctl[5] ? clk_o : own_o));
  assign din_o = (!pins_i.cs_b && !pins_i.rd_b) ? rval : pat;
  assign int_b_o = (ints == 3'd0);
  // Register writes, byte timing and the per-byte interrupt.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {ctl, dreg, k, own_o, clk_o, busy, rx, aph, seen, tmr, ints, ev_o, init_ok_o} <= '0;
      {wr_q, rd_q} <= 2'b11;
      pat <= 8'hA5;
      ev_data_o <= 9'h000;
    end else begin
      wr_q <= pins_i.wr_b;
      rd_q <= pins_i.rd_b;
      pat <= ~pat;
      ev_o <= 1'b0;
      if (ints != 3'd0) ints <= ints - 3'd1;
      if (tmr != 6'd0) tmr <= tmr - 6'd1;
      if (wr_go || rd_go) seen <= 1'b1;
      if (!seen && (wr_go || rd_go)) init_ok_o <= wr_go && pins_i.sel && pins_i.dout == 8'h00;
      if (wr_go && pins_i.sel) begin
        ctl <= pins_i.dout;
        busy <= !pins_i.dout[1] && (busy || pins_i.dout[2]);
      end
      if (wr_go && pins_i.sel && pins_i.dout[1]) tmr <= 6'd0;
      if (wr_go && pins_i.sel && pins_i.dout[2] && !pins_i.dout[1]) begin
        rx <= dreg[0];
        aph <= 1'b1;
        k <= 8'h00;
        tmr <= 6'd40;
      end
      if (wr_go && !pins_i.sel && dptr) begin
        dreg <= pins_i.dout;
        if (busy && !rx) tmr <= 6'd40;
      end
      if (wr_go && !pins_i.sel && !dptr && ctl[5]) clk_o <= pins_i.dout;
      if (wr_go && !pins_i.sel && ctl[6:4] == 3'b000) own_o <= pins_i.dout;
      if (rd_go && !pins_i.sel && dptr && busy && rx) tmr <= 6'd40;
      if (tmr == 6'd1) begin
        ev_o <= 1'b1;
        ev_data_o <= {ctl[0], (rx && !aph) ? rx_seed_i + k : dreg};
        if (rx && !aph) dreg <= rx_seed_i + k;
        k <= k + {7'h00, rx && !aph};
        aph <= 1'b0;
        if (ctl[3]) ints <= 3'd4;
      end
    end
  end
endmodule : ctl_device_model

// [tb/tb_transfer_host.sv]
// Purpose: Self-checking bench for the transfer host.
// Assumes: APB master tasks and a behavioural device on the far side.
// Notes: Bus bytes are matched in order against a queue of expected bytes.
`timescale 1ns/1ps
module tb_transfer_host;
  logic clock_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, int_b, ev, ok, rerr;
  logic [7:0] paddr_i, seed_b, din, own, clk, a;
  logic [31:0] pwdata_i, prdata_o, rdv, rs, r;
  logic [8:0] evd;
  logic [8:0] exp_q[$];
  wire seq_pkg::dev_pins_t pins;
  int num_errors, compares, n, t;
  int txn[4] = '{0, 1, 5, 16};
  int rxn[2] = '{1, 3};
  transfer_host dut (.clock_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .dev_din_i(din), .dev_int_b_i(int_b),
    .dev_cs_b_o(pins.cs_b), .dev_rd_b_o(pins.rd_b), .dev_wr_b_o(pins.wr_b),
    .dev_sel_o(pins.sel), .dev_dout_o(pins.dout), .dev_doe_o(pins.doe));
  ctl_device_model model (.clock_i, .rst_b_i, .pins_i(pins), .din_o(din), .int_b_o(int_b),
    .rx_seed_i(seed_b), .ev_o(ev), .ev_data_o(evd), .init_ok_o(ok), .own_o(own), .clk_o(clk));
  // Free-running 100 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; the request is held until ready is sampled high.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    rdv = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (k >= 50) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : apb
  // Drain expected bytes, poll for completion, then check the status fields.
  task automatic fin(input int cnt, input logic dir);
    t = 0;
    while (exp_q.size() != 0 && t < 20000) begin
      @(posedge clock_i);
      t++;
    end
    do begin
      apb(1'b0, 8'h04, 32'h0);
      t++;
    end while (rdv[0] !== 1'b1 && t < 20200);
    if (t >= 20200) begin
      num_errors++;
      tally_and_finish();
    end
    chk("queue left", 32'h0, 32'(exp_q.size()));
    chk("direction", {31'h0, dir}, {31'h0, rdv[1]});
    chk("counter", 32'(cnt), {24'h0, rdv[15:8]});
  endtask : fin
  // Each device byte is compared with the oldest note in the queue.
  always @(posedge clock_i) begin
    if (ev === 1'b1) begin
      chk("bus byte", exp_q.size() != 0 ? {23'h0, exp_q.pop_front()} : '1, {23'h0, evd});
    end
  end
  initial begin
    rs = 32'hB7D7C755;
    {num_errors, compares} = '0;
    {rst_b_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, seed_b} = '0;
    repeat (6) @(posedge clock_i);
    rst_b_i <= 1'b1;
    for (t = 0; t < 400 && clk !== 8'h1C; t++) @(posedge clock_i);
    chk("first access", 32'h1, {31'h0, ok});
    chk("own address", 32'h55, {24'h0, own});
    chk("clock byte", 32'h1C, {24'h0, clk});
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdv);
    $display("test init done");
    foreach (txn[i]) begin
      n = txn[i];
      r = xs();
      a = {r[7:1], 1'b0};
      exp_q.push_back({1'b1, a});
      apb(1'b1, 8'h08, 32'h00001C55);
      for (int j = 0; j < n; j++) begin
        r = xs();
        apb(1'b1, 8'h0C, {24'h0, r[7:0]});
        exp_q.push_back({1'b1, r[7:0]});
      end
      apb(1'b1, 8'h00, {8'h00, 8'(n), 8'h03, a});
      for (t = 0; t < 2000 && int_b !== 1'b0; t++) @(posedge clock_i);
      apb(1'b1, 8'h00, {8'h00, 8'h02, 8'h03, a ^ 8'h10});
      fin(n, 1'b1);
      $display("test transmit %0d done", n);
    end
    foreach (rxn[i]) begin
      n = rxn[i];
      r = xs();
      seed_b <= r[7:0];
      a = {r[15:9], 1'b1};
      exp_q.push_back({1'b1, a});
      for (int j = 0; j < n; j++) exp_q.push_back({j != n - 1, 8'(r[7:0] + j)});
      apb(1'b1, 8'h00, {8'h00, 8'(n), 8'h01, a});
      fin(n + 1, 1'b0);
      for (int j = 0; j < n; j++) begin
        apb(1'b1, 8'h08, {12'h0, 4'(j), 16'h1C55});
        apb(1'b0, 8'h0C, 32'h0);
        chk("stored byte", {24'h0, 8'(r[7:0] + j)}, rdv);
      end
      $display("test receive %0d done", n);
    end
    tally_and_finish();
  end
endmodule : tb_transfer_host
